// file: hdl/dscg_clock_gen.sv
// dual source clock generator: source select, prescaler, power modes
`timescale 1ns/10ps
`default_nettype none
`include "dscg_defines.svh"

module dscg_clock_gen
  import dscg_pkg::*;
(
  // system clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rstn,
  // oscillator sources and timer0 pin, asynchronous to sys_clk
  input  wire logic       clock_source_a,
  input  wire logic       clock_source_b,
  input  wire logic       timer0_input_pin,
  // fuse strap, sampled once after reset release
  input  wire logic       fuse_source_choice,
  // oscillator control write
  input  wire logic       osc_ctrl_wr,
  input  wire logic [2:0] osc_ctrl_wdata,
  // clock source select write
  input  wire logic       select_wr,
  input  wire logic       select_wdata,
  // prescaler reload write
  input  wire logic       reload_wr,
  input  wire logic [7:0] reload_wdata,
  // power control write
  input  wire logic       power_ctrl_wr,
  input  wire logic [1:0] power_ctrl_wdata,
  // speed mode level
  input  wire logic       double_speed_mode,
  // wake requests from the interrupt logic
  input  wire logic       irq_wake,
  input  wire logic       ext_wake,
  input  wire logic       kbd_wake,
  // oscillator halts
  output logic            source_a_halt,
  output logic            source_b_halt,
  // generated clock pulses
  output logic            cpu_clk_pulse,
  output logic            periph_clk_pulse,
  output logic            machine_cycle_pulse,
  output logic            timer0_count_pulse,
  // control and status readback
  output logic            source_a_enable,
  output logic            source_b_enable,
  output logic            clock_source_select,
  output logic            timer0_subclock_select,
  output logic [7:0]      prescaler_reload,
  output logic            sleep_request_bit,
  output logic            deep_sleep_bit,
  output logic            active_source_select
);

  // divider count minus one for a reload value and speed mode
  function automatic logic [9:0] ratio_m1(input logic [7:0] rl,
                                          input logic       x2);
    logic [9:0] diff;
    diff = {2'b00, `DSCG_RELOAD_TOP - rl};
    if (rl == `DSCG_RELOAD_FULL) begin
      ratio_m1 = x2 ? `DSCG_FULL_X2_M1 : `DSCG_FULL_STD_M1;
    end else if (x2) begin
      ratio_m1 = (diff << `DSCG_SHIFT_X2) - 10'h001;
    end else begin
      ratio_m1 = (diff << `DSCG_SHIFT_STD) - 10'h001;
    end
  endfunction

  // ------------------------------------------------------------------
  // input synchronisers: the first stage feeds only the second
  logic [2:0] sync_a_q;
  logic [2:0] sync_b_q;
  logic [2:0] sync_t0_q;
  logic [2:0] sync_a_d;
  logic [2:0] sync_b_d;
  logic [2:0] sync_t0_d;
  logic       tick_a;
  logic       tick_b;
  logic       fall_t0;

  // shift each pin through its chain; third stage is for edge detect
  always_comb begin
    sync_a_d  = {sync_a_q[1:0], clock_source_a};
    sync_b_d  = {sync_b_q[1:0], clock_source_b};
    sync_t0_d = {sync_t0_q[1:0], timer0_input_pin};
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sync_a_q  <= 3'h0;
      sync_b_q  <= 3'h0;
      sync_t0_q <= 3'h0;
    end else begin
      sync_a_q  <= sync_a_d;
      sync_b_q  <= sync_b_d;
      sync_t0_q <= sync_t0_d;
    end
  end

  // rising edges of the sources, falling edge of the timer0 pin
  assign tick_a  = sync_a_q[1] & ~sync_a_q[2];
  assign tick_b  = sync_b_q[1] & ~sync_b_q[2];
  assign fall_t0 = ~sync_t0_q[1] & sync_t0_q[2];

  // ------------------------------------------------------------------
  // control bits and power state
  logic          fuse_done_q;
  logic          a_en_q;
  logic          b_en_q;
  logic          cks_q;
  logic          sub_sel_q;
  logic [7:0]    reload_q;
  dscg_mode_type mode_q;
  logic          fuse_done_d;
  logic          a_en_d;
  logic          b_en_d;
  logic          cks_d;
  logic          sub_sel_d;
  logic [7:0]    reload_d;
  dscg_mode_type mode_d;
  logic          wr_idle;
  logic          wr_down;

  assign wr_idle = power_ctrl_wr & power_ctrl_wdata[`DSCG_POWER_CONTROL_REGISTER_IDLE];
  assign wr_down = power_ctrl_wr & power_ctrl_wdata[`DSCG_POWER_CONTROL_REGISTER_DOWN];

  // software writes, fuse load in the first cycle after reset release
  always_comb begin
    fuse_done_d = 1'b1;
    a_en_d      = a_en_q;
    b_en_d      = b_en_q;
    cks_d       = cks_q;
    sub_sel_d   = sub_sel_q;
    reload_d    = reload_q;
    if (!fuse_done_q) begin
      a_en_d = fuse_source_choice;
      b_en_d = ~fuse_source_choice;
      cks_d  = fuse_source_choice;
    end else begin
      // enables and select are only touched by writes, never by wake
      if (osc_ctrl_wr) begin
        a_en_d    = osc_ctrl_wdata[`DSCG_OSC_A_EN];
        b_en_d    = osc_ctrl_wdata[`DSCG_OSC_B_EN];
        sub_sel_d = osc_ctrl_wdata[`DSCG_OSC_SUB_SEL];
      end
      if (select_wr) begin
        cks_d = select_wdata;
      end
    end
    if (reload_wr) begin
      reload_d = reload_wdata;
    end
  end

  // power state: in idle a sleep write wins over a same-cycle wake; in power-down the wake wins
  always_comb begin
    mode_d = mode_q;
    case (mode_q)
      DSCG_RUN: begin
        if (wr_down) begin
          mode_d = DSCG_DOWN;
        end else if (wr_idle) begin
          mode_d = DSCG_IDLE;
        end
      end
      DSCG_IDLE: begin
        if (wr_down) begin
          mode_d = DSCG_DOWN;
        end else if (!wr_idle && irq_wake) begin
          mode_d = DSCG_RUN;
        end
      end
      DSCG_DOWN: begin
        // only external or keyboard wake; plain interrupts are ignored
        if (ext_wake || kbd_wake) begin
          mode_d = DSCG_RUN;
        end
      end
      default: begin
        mode_d = DSCG_RUN;
      end
    endcase
  end

  // async reset drops out of any sleep state and clears both bits
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      fuse_done_q <= 1'b0;
      a_en_q      <= 1'b1;
      b_en_q      <= 1'b0;
      cks_q       <= 1'b1;
      sub_sel_q   <= 1'b0;
      reload_q    <= `DSCG_RELOAD_RST;
      mode_q      <= DSCG_RUN;
    end else begin
      fuse_done_q <= fuse_done_d;
      a_en_q      <= a_en_d;
      b_en_q      <= b_en_d;
      cks_q       <= cks_d;
      sub_sel_q   <= sub_sel_d;
      reload_q    <= reload_d;
      mode_q      <= mode_d;
    end
  end

  // ------------------------------------------------------------------
  // prescaler down counter and clock outputs
  logic [9:0] cnt_q;
  logic       act_sel_q;
  logic       cpu_q;
  logic       periph_q;
  logic [2:0] phase_q;
  logic       mc_q;
  logic       t0_q;
  logic       halt_a_q;
  logic       halt_b_q;
  logic [9:0] cnt_d;
  logic       act_sel_d;
  logic       cpu_d;
  logic       periph_d;
  logic [2:0] phase_d;
  logic       mc_d;
  logic       t0_d;
  logic       halt_a_d;
  logic       halt_b_d;
  logic       src_tick;
  logic       boundary;
  logic       pdown;

  assign pdown = (mode_q == DSCG_DOWN);
  // only the source already in use drives the counter
  assign src_tick = ~pdown & (act_sel_q ? tick_a : tick_b);
  assign boundary = src_tick & (cnt_q == 10'h000);

  // new select, reload and speed mode are taken only at a period end,
  // so no output period is ever shortened; a stopped new source stalls
  always_comb begin
    cnt_d     = cnt_q;
    act_sel_d = fuse_done_q ? act_sel_q : fuse_source_choice;
    if (boundary) begin
      act_sel_d = cks_q;
      cnt_d     = ratio_m1(reload_q, double_speed_mode);
    end else if (src_tick) begin
      cnt_d = cnt_q - 10'h001;
    end
    cpu_d    = boundary & (mode_q == DSCG_RUN);
    periph_d = boundary;
    // six cpu clock pulses make one machine cycle
    phase_d = phase_q;
    mc_d    = 1'b0;
    if (cpu_d) begin
      if (phase_q == `DSCG_PHASES_M1) begin
        phase_d = 3'h0;
        mc_d    = 1'b1;
      end else begin
        phase_d = phase_q + 3'h1;
      end
    end
    // timer0 source: pin falling edge or sub clock edge
    t0_d     = ~pdown & (sub_sel_q ? tick_b : fall_t0);
    halt_a_d = pdown | ~a_en_q;
    halt_b_d = pdown | ~b_en_q;
  end

  // all outputs of this group leave from flip-flops
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q     <= 10'h000;
      act_sel_q <= 1'b1;
      cpu_q     <= 1'b0;
      periph_q  <= 1'b0;
      phase_q   <= 3'h0;
      mc_q      <= 1'b0;
      t0_q      <= 1'b0;
      halt_a_q  <= 1'b0;
      halt_b_q  <= 1'b1;
    end else begin
      cnt_q     <= cnt_d;
      act_sel_q <= act_sel_d;
      cpu_q     <= cpu_d;
      periph_q  <= periph_d;
      phase_q   <= phase_d;
      mc_q      <= mc_d;
      t0_q      <= t0_d;
      halt_a_q  <= halt_a_d;
      halt_b_q  <= halt_b_d;
    end
  end

  // outputs
  assign source_a_halt          = halt_a_q;
  assign source_b_halt          = halt_b_q;
  assign cpu_clk_pulse          = cpu_q;
  assign periph_clk_pulse       = periph_q;
  assign machine_cycle_pulse    = mc_q;
  assign timer0_count_pulse     = t0_q;
  assign source_a_enable        = a_en_q;
  assign source_b_enable        = b_en_q;
  assign clock_source_select    = cks_q;
  assign timer0_subclock_select = sub_sel_q;
  assign prescaler_reload       = reload_q;
  assign sleep_request_bit      = (mode_q == DSCG_IDLE);
  assign deep_sleep_bit         = pdown;
  assign active_source_select   = act_sel_q;

endmodule // dscg_clock_gen

`default_nettype wire

// file: inc/dscg_defines.svh
// named constants for the dual source clock generator
`ifndef DSCG_DEFINES_SVH
`define DSCG_DEFINES_SVH

// prescaler reload value after reset, and the value giving full rate
`define DSCG_RELOAD_RST   8'hFF
`define DSCG_RELOAD_FULL  8'hFF
// top of the reload range; the reload value is subtracted from it
`define DSCG_RELOAD_TOP   8'hFF
// divider count minus one for the full-rate reload value
`define DSCG_FULL_STD_M1  10'h001
`define DSCG_FULL_X2_M1   10'h000
// divide-by multipliers as left shifts: 4x standard, 2x double speed
`define DSCG_SHIFT_STD    2
`define DSCG_SHIFT_X2     1
// cpu clock pulses per machine cycle, minus one
`define DSCG_PHASES_M1    3'h5
// power control write data bit positions
`define DSCG_POWER_CONTROL_REGISTER_IDLE    0
`define DSCG_POWER_CONTROL_REGISTER_DOWN    1
// oscillator control write data bit positions
`define DSCG_OSC_A_EN     0
`define DSCG_OSC_B_EN     1
`define DSCG_OSC_SUB_SEL  2

`endif

// file: inc/dscg_pkg.sv
// types shared by the dual source clock generator
package dscg_pkg;

  // power state of the generator
  typedef enum logic [1:0] {
    DSCG_RUN,
    DSCG_IDLE,
    DSCG_DOWN
  } dscg_mode_type;

endpackage

// file: tb/dscg_clock_gen_assertions.sv
// port assertions for the dual source clock generator
`timescale 1ns/10ps
`default_nettype none

module dscg_checker (
  // clock, reset and requests
  input wire logic       sys_clk,
  input wire logic       rstn,
  input wire logic       select_wr,
  input wire logic       select_wdata,
  input wire logic       reload_wr,
  input wire logic [7:0] reload_wdata,
  input wire logic       power_ctrl_wr,
  input wire logic [1:0] power_ctrl_wdata,
  input wire logic       osc_ctrl_wr,
  input wire logic       irq_wake,
  input wire logic       ext_wake,
  input wire logic       kbd_wake,
  // outputs under watch
  input wire logic       source_a_halt,
  input wire logic       source_b_halt,
  input wire logic       cpu_clk_pulse,
  input wire logic       periph_clk_pulse,
  input wire logic       machine_cycle_pulse,
  input wire logic       timer0_count_pulse,
  input wire logic       source_a_enable,
  input wire logic       source_b_enable,
  input wire logic       clock_source_select,
  input wire logic [7:0] prescaler_reload,
  input wire logic       sleep_request_bit,
  input wire logic       deep_sleep_bit
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  // halts trail enables and deep sleep by one edge
  halt_a_follow_a: assert property (source_a_halt ==
    $past(deep_sleep_bit || !source_a_enable)) else $error("halt a wrong");
  halt_b_follow_a: assert property (source_b_halt ==
    $past(deep_sleep_bit || !source_b_enable)) else $error("halt b wrong");
  // clock gating by power state
  // a pulse launched on the edge that enters sleep is still legal
  cpu_sleep_off_a: assert property (
    $past(sleep_request_bit || deep_sleep_bit) |-> !cpu_clk_pulse)
    else $error("cpu clock in sleep");
  periph_down_off_a: assert property (deep_sleep_bit && $past(deep_sleep_bit)
    |-> !periph_clk_pulse && !timer0_count_pulse) else $error("clock in down");
  cpu_with_periph_a: assert property (cpu_clk_pulse |-> periph_clk_pulse)
    else $error("cpu pulse alone");
  machine_on_cpu_a: assert property (machine_cycle_pulse |-> cpu_clk_pulse)
    else $error("machine pulse alone");
  // entry and exit of the power states
  idle_enter_a: assert property (power_ctrl_wr && power_ctrl_wdata == 2'h1
    && !deep_sleep_bit |=> sleep_request_bit) else $error("no idle");
  down_enter_a: assert property (power_ctrl_wr && power_ctrl_wdata[1]
    && !deep_sleep_bit |=> deep_sleep_bit && !sleep_request_bit
    ##1 source_a_halt && source_b_halt) else $error("no power-down");
  idle_exit_a: assert property (sleep_request_bit && irq_wake && !power_ctrl_wr
    && !osc_ctrl_wr && !select_wr |=> !sleep_request_bit
    && $stable(source_a_enable) && $stable(source_b_enable)
    && $stable(clock_source_select)) else $error("bad idle exit");
  down_hold_a: assert property (deep_sleep_bit && !ext_wake && !kbd_wake
    |=> deep_sleep_bit) else $error("left power-down");
  kbd_exit_a: assert property (deep_sleep_bit && kbd_wake
    |=> !deep_sleep_bit) else $error("no keyboard exit");
  // control writes land one edge later
  reload_take_a: assert property (reload_wr |=>
    prescaler_reload == $past(reload_wdata)) else $error("reload lost");
  select_take_a: assert property (select_wr |=>
    clock_source_select == $past(select_wdata)) else $error("select lost");

  idle_seen_c: cover property (sleep_request_bit && periph_clk_pulse);
  down_seen_c: cover property (deep_sleep_bit && kbd_wake);
  machine_seen_c: cover property (machine_cycle_pulse);
endmodule // dscg_checker

bind dscg_clock_gen dscg_checker chk (.*);

`default_nettype wire

// file: tb/dscg_osc_model.sv
// oscillator hard block model driven by the generator's halt output
`timescale 1ns/10ps
`default_nettype none

module dscg_osc_model #(
  parameter int HALF_NS = 500
) (
  // stop request from the generator
  input  wire logic halt,
  // oscillator output
  output var  logic osc
);
  // a stopped crystal stands low, so no stale edge survives a halt
  initial begin
    osc = 1'b0;
    #37;
    forever begin
      #HALF_NS;
      osc = !halt && !osc;
    end
  end
endmodule // dscg_osc_model

`default_nettype wire

// file: tb/testbench.sv
// self-checking bench for the dual source clock generator
`timescale 1ns/10ps
`default_nettype none

module testbench;
  import dscg_pkg::*;
  typedef struct {logic [7:0] r; logic x; logic s; int n;} dscg_row_type;
  logic       sys_clk, rstn, clock_source_a, clock_source_b, timer0_input_pin;
  logic       fuse_source_choice, osc_ctrl_wr, select_wr, select_wdata;
  logic       reload_wr, power_ctrl_wr, double_speed_mode;
  logic       irq_wake, ext_wake, kbd_wake;
  logic [2:0] osc_ctrl_wdata;
  logic [7:0] reload_wdata;
  logic [1:0] power_ctrl_wdata;
  logic       source_a_halt, source_b_halt, cpu_clk_pulse, periph_clk_pulse;
  logic       machine_cycle_pulse, timer0_count_pulse, source_a_enable;
  logic       source_b_enable, clock_source_select, timer0_subclock_select;
  logic       sleep_request_bit, deep_sleep_bit, active_source_select;
  logic [7:0] prescaler_reload;
  int         num_errors = 0;
  int         comparisons = 0;
  int         n, c_cpu, c_per, c_t0, c_mc;
  // source A ticks every 10 cycles, B every 15
  dscg_row_type rows [9] = '{'{8'hFF, 0, 1, 20}, '{8'hFF, 1, 1, 10},
    '{8'hFE, 0, 1, 40}, '{8'hFE, 1, 1, 20}, '{8'hF0, 0, 1, 600},
    '{8'h00, 1, 1, 5100}, '{8'h00, 0, 1, 10200}, '{8'hFF, 0, 0, 30},
    '{8'hFD, 1, 0, 60}};

  dscg_clock_gen dut (.*);
  dscg_osc_model #(.HALF_NS(500)) osc_a (.halt(source_a_halt),
    .osc(clock_source_a));
  dscg_osc_model #(.HALF_NS(750)) osc_b (.halt(source_b_halt),
    .osc(clock_source_b));

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = !sys_clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask
  // one-cycle write strobe, data set by the caller beforehand
  task automatic strobe(ref logic s);
    @(negedge sys_clk);
    s = 1'b1;
    @(negedge sys_clk);
    s = 1'b0;
  endtask
  task automatic wait_n(input int k);
    repeat (k) @(negedge sys_clk);
  endtask
  // pulse counts over a window, sampled mid-cycle
  task automatic count(input int k);
    c_cpu = 0;
    c_per = 0;
    c_t0 = 0;
    c_mc = 0;
    repeat (k) begin
      @(negedge sys_clk);
      c_cpu += int'(cpu_clk_pulse === 1'b1);
      c_per += int'(periph_clk_pulse === 1'b1);
      c_t0 += int'(timer0_count_pulse === 1'b1);
      c_mc += int'(machine_cycle_pulse === 1'b1);
    end
  endtask
  // cycles between two peripheral pulses, bounded
  task automatic period();
    n = 0;
    while (periph_clk_pulse !== 1'b1 && n < 30000) begin
      @(negedge sys_clk);
      n++;
    end
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while (periph_clk_pulse !== 1'b1 && n < 30000);
  endtask
  task automatic do_reset(input logic f);
    fuse_source_choice = f;
    rstn = 1'b0;
    wait_n(12);
    check({source_a_halt, source_b_halt, prescaler_reload}, 10'h1FF);
    rstn = 1'b1;
    wait_n(3);
    check({source_a_enable, source_b_enable, clock_source_select,
      source_a_halt, source_b_halt}, f ? 5'h15 : 5'h0A);
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial begin
    {osc_ctrl_wr, select_wr, select_wdata, reload_wr, power_ctrl_wr} = '0;
    {double_speed_mode, irq_wake, ext_wake, kbd_wake, timer0_input_pin} = '0;
    {osc_ctrl_wdata, reload_wdata, power_ctrl_wdata} = '0;
    do_reset(1'b1);
    osc_ctrl_wdata = 3'h3;
    strobe(osc_ctrl_wr);
    // divider rows: both sources running, select kept on a live source
    foreach (rows[i]) begin
      reload_wdata = rows[i].r;
      select_wdata = rows[i].s;
      double_speed_mode = rows[i].x;
      strobe(reload_wr);
      strobe(select_wr);
      period();
      period();
      check(n, rows[i].n);
    end
    // idle on source B, then stop the unused source A
    power_ctrl_wdata = 2'h1;
    strobe(power_ctrl_wr);
    count(300);
    check({sleep_request_bit, c_cpu == 0, c_per > 3}, 3'h7);
    osc_ctrl_wdata = 3'h2;
    strobe(osc_ctrl_wr);
    count(300);
    check({source_a_halt, source_b_halt, c_per > 3}, 3'h5);
    strobe(irq_wake);
    wait_n(2);
    check({sleep_request_bit, source_a_enable, source_b_enable,
      clock_source_select}, 4'h2);
    // six cpu pulses per machine pulse on a steady 60-cycle period
    count(720);
    check(c_cpu, 12);
    check(c_mc, 2);
    // power-down ignores the interrupt wake, keyboard leaves it
    power_ctrl_wdata = 2'h3;
    strobe(power_ctrl_wr);
    irq_wake = 1'b1;
    count(300);
    irq_wake = 1'b0;
    check({deep_sleep_bit, sleep_request_bit, source_a_halt, source_b_halt,
      c_per == 0}, 5'h17);
    strobe(kbd_wake);
    count(300);
    check({deep_sleep_bit, source_a_halt, source_b_halt, c_cpu > 0},
      4'h5);
    // external line held well past the oscillator restart
    strobe(power_ctrl_wr);
    wait_n(5);
    ext_wake = 1'b1;
    wait_n(20);
    ext_wake = 1'b0;
    check({deep_sleep_bit, source_b_halt}, 2'h0);
    // timer0 from its pin, then from the sub clock
    count(5);
    for (int i = 0; i < 5; i++) begin
      timer0_input_pin = 1'b1;
      wait_n(5);
      timer0_input_pin = 1'b0;
      count(5);
      check(c_t0, 1);
    end
    osc_ctrl_wdata = 3'h6;
    strobe(osc_ctrl_wr);
    count(150);
    check({timer0_subclock_select, c_t0[7:0]}, 9'h10A);
    // reset from power-down restarts on the fused source
    strobe(power_ctrl_wr);
    wait_n(5);
    do_reset(1'b0);
    // prescaler must follow the fused source, not the stopped one
    count(300);
    check({active_source_select, c_per > 0}, 2'h1);
    wrap_up();
  end

  // hang guard, well beyond the longest divider rows
  initial begin
    #8ms;
    num_errors++;
    wrap_up();
  end
endmodule // testbench

`default_nettype wire
